// ===== tsr_status_bank.sv
/*
 * tsr_status_bank: read-only status register bank of a DC network transducer,
 * reached over APB, with the card state machine and network clock monitor.
 * Assumes status pins and straps are asynchronous to pclk; the archive page
 * comes from logic on pclk.
 */
// The APB interface to the registers is this design's own decision.
// How it works
// RULE1 - the card state register returns 0 absent, 1 uninstalled, 2 failed install, 4 installed, 5 full, 6 installing.
// RULE2 - an installed card found write-protected reports code 3 and is uninstalled at once.
// RULE3 - measurement bit 7 flags voltage below threshold and bit 8 current below threshold.
// RULE4 - measurement bit 9 flags voltage above threshold and bit 10 current above threshold.
// RULE5 - network bit 0 shows the network option is fitted.
// RULE6 - network bit 1 shows autonegotiation running and bit 2 autonegotiation done.
// RULE7 - network bit 3 shows a connection is up and bit 6 the cable is attached.
// RULE8 - network bit 4 shows DHCP-acquired parameters and bit 5 a pending DHCP refresh.
// RULE9 - network bit 7 shows an FTP session and bit 8 energy-saving mode.
// RULE10 - network bit 10 is 1 while the network clock toggles and 0 when it is missing.
// RULE11 - the serial register returns the full 16-bit serial number.
// RULE12 - the date register holds year in bits 11:6, month in bits 5:0, bits 15:12 zero.
// RULE13 - the options register holds the power variant in bits 15:14, 01 high and 10 low.
// RULE14 - the options register holds a 3-bit accessory code: 000 none, 001 slot, 010 network with memory.
// RULE15 - the language register holds the language in bit 6, 0 Polish and 1 English, rest zero.
// RULE16 - the archive start register returns the start page, limited to 8192.
// RULE17 - reserved bits and registers read zero and writes change nothing.
`timescale 1ns/1ps
`default_nettype none

module tsr_status_bank #(
	parameter int CLK_TIMEOUT_CYC = tsr_pkg::NET_CLK_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// card events (asynchronous levels)
	input wire logic card_detect,
	input wire logic card_install_req,
	input wire logic card_install_done,
	input wire logic card_install_err,
	input wire logic card_wprot,
	input wire logic card_full_det,
	// measurement threshold levels (asynchronous)
	input wire logic volt_below,
	input wire logic curr_below,
	input wire logic volt_above,
	input wire logic curr_above,
	// network status levels (asynchronous)
	input wire logic net_fitted,
	input wire logic net_aneg_busy,
	input wire logic net_aneg_done,
	input wire logic net_connected,
	input wire logic net_dhcp_lease,
	input wire logic net_dhcp_renew,
	input wire logic net_cable_ok,
	input wire logic net_ftp_up,
	input wire logic net_power_save,
	input wire logic net_ref_clk,
	// production straps (static, asynchronous)
	input wire logic [15:0] strap_serial,
	input wire logic [5:0] strap_year,
	input wire logic [5:0] strap_month,
	input wire logic [1:0] strap_power,
	input wire logic [2:0] strap_accessory,
	input wire logic strap_language,
	// archive pointer (pclk domain)
	input wire logic [13:0] archive_start_page,
	// card mount state to the rest of the device
	output logic card_mounted
);

	localparam int NSYNC = 54;
	localparam logic [7:0] TIMEOUT = 8'(CLK_TIMEOUT_CYC);

	// =====================================================================
	// input synchroniser
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync1_ff;
	logic [NSYNC-1:0] sync2_ff;

	assign async_in = {card_detect, card_install_req, card_install_done, card_install_err,
		card_wprot, card_full_det, volt_below, curr_below, volt_above, curr_above,
		net_fitted, net_aneg_busy, net_aneg_done, net_connected, net_dhcp_lease,
		net_dhcp_renew, net_cable_ok, net_ftp_up, net_power_save, net_ref_clk,
		strap_serial, strap_year, strap_month, strap_power, strap_accessory, strap_language};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= async_in;
			sync2_ff <= sync1_ff;
		end
	end

	logic det_s, req_s, done_s, err_s, wp_s, full_s;
	logic [3:0] meas_s;
	logic [8:0] net_s;
	logic refclk_s;
	logic [33:0] strap_s;

	assign {det_s, req_s, done_s, err_s, wp_s, full_s} = sync2_ff[53:48];
	assign meas_s = sync2_ff[47:44];
	assign net_s = sync2_ff[43:35];
	assign refclk_s = sync2_ff[34];
	assign strap_s = sync2_ff[33:0];

	// =====================================================================
	// card state machine
	tsr_pkg::tsr_card_st_t card_st_ff;
	tsr_pkg::tsr_card_st_t nxt_card_st;

	always_comb begin
		nxt_card_st = card_st_ff;
		if (!det_s) begin
			nxt_card_st = tsr_pkg::TSR_ST_ABSENT;
		end else begin
			case (card_st_ff)
				tsr_pkg::TSR_ST_ABSENT: begin
					nxt_card_st = tsr_pkg::TSR_ST_UNINSTALLED;
				end
				tsr_pkg::TSR_ST_UNINSTALLED, tsr_pkg::TSR_ST_FAILED, tsr_pkg::TSR_ST_WPROT: begin
					if (req_s) begin
						nxt_card_st = tsr_pkg::TSR_ST_INSTALLING;
					end
				end
				tsr_pkg::TSR_ST_INSTALLING: begin
					if (err_s) begin
						nxt_card_st = tsr_pkg::TSR_ST_FAILED;
					end else if (done_s) begin
						nxt_card_st = tsr_pkg::TSR_ST_INSTALLED;
					end
				end
				// RULE2 write-protect uninstalls
				tsr_pkg::TSR_ST_INSTALLED: begin
					if (wp_s) begin
						nxt_card_st = tsr_pkg::TSR_ST_WPROT;
					end else if (full_s) begin
						nxt_card_st = tsr_pkg::TSR_ST_FULL;
					end
				end
				tsr_pkg::TSR_ST_FULL: begin
					if (wp_s) begin
						nxt_card_st = tsr_pkg::TSR_ST_WPROT;
					end else if (!full_s) begin
						nxt_card_st = tsr_pkg::TSR_ST_INSTALLED;
					end
				end
				default: begin
					nxt_card_st = tsr_pkg::TSR_ST_ABSENT;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			card_st_ff <= tsr_pkg::TSR_ST_ABSENT;
		end else begin
			card_st_ff <= nxt_card_st;
		end
	end

	// RULE1 state to code
	logic [2:0] card_code;
	always_comb begin
		case (card_st_ff)
			tsr_pkg::TSR_ST_UNINSTALLED: card_code = tsr_pkg::CARD_UNINSTALLED;
			tsr_pkg::TSR_ST_FAILED: card_code = tsr_pkg::CARD_FAILED;
			tsr_pkg::TSR_ST_WPROT: card_code = tsr_pkg::CARD_WPROT;
			tsr_pkg::TSR_ST_INSTALLING: card_code = tsr_pkg::CARD_INSTALLING;
			tsr_pkg::TSR_ST_INSTALLED: card_code = tsr_pkg::CARD_INSTALLED;
			tsr_pkg::TSR_ST_FULL: card_code = tsr_pkg::CARD_FULL;
			default: card_code = tsr_pkg::CARD_ABSENT;
		endcase
	end

	// RULE2 mount follows state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			card_mounted <= 1'b0;
		end else begin
			card_mounted <= (nxt_card_st == tsr_pkg::TSR_ST_INSTALLED) || (nxt_card_st == tsr_pkg::TSR_ST_FULL);
		end
	end

	// =====================================================================
	// measurement and network flags
	logic [15:0] meas_ff;
	logic [15:0] net_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas_ff <= '0;
		end else begin
			meas_ff <= '0;
			// RULE3 below threshold
			meas_ff[tsr_pkg::MEAS_VOLT_BELOW] <= meas_s[3];
			meas_ff[tsr_pkg::MEAS_CURR_BELOW] <= meas_s[2];
			// RULE4 above threshold
			meas_ff[tsr_pkg::MEAS_VOLT_ABOVE] <= meas_s[1];
			meas_ff[tsr_pkg::MEAS_CURR_ABOVE] <= meas_s[0];
		end
	end

	// clock monitor: cycles since last edge of network clock
	logic refclk_d_ff;
	logic [7:0] clk_idle_ff;
	logic clk_edge;

	assign clk_edge = refclk_s ^ refclk_d_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refclk_d_ff <= 1'b0;
			clk_idle_ff <= TIMEOUT;
		end else begin
			refclk_d_ff <= refclk_s;
			if (clk_edge) begin
				clk_idle_ff <= '0;
			end else if (clk_idle_ff != TIMEOUT) begin
				clk_idle_ff <= clk_idle_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			net_ff <= '0;
		end else begin
			net_ff <= '0;
			// RULE5 option fitted
			net_ff[tsr_pkg::NET_FITTED] <= net_s[8];
			// RULE6 autonegotiation
			net_ff[tsr_pkg::NET_ANEG_BUSY] <= net_s[7];
			net_ff[tsr_pkg::NET_ANEG_DONE] <= net_s[6];
			// RULE7 connection and cable
			net_ff[tsr_pkg::NET_CONNECTED] <= net_s[5];
			net_ff[tsr_pkg::NET_CABLE_OK] <= net_s[2];
			// RULE8 dhcp state
			net_ff[tsr_pkg::NET_DHCP_LEASE] <= net_s[4];
			net_ff[tsr_pkg::NET_DHCP_RENEW] <= net_s[3];
			// RULE9 ftp and power save
			net_ff[tsr_pkg::NET_FTP_UP] <= net_s[1];
			net_ff[tsr_pkg::NET_POWER_SAVE] <= net_s[0];
			// RULE10 clock present
			net_ff[tsr_pkg::NET_CLK_OK] <= clk_edge || (clk_idle_ff != TIMEOUT);
		end
	end

	// =====================================================================
	// production straps, caught once after reset release
	logic [1:0] strap_cnt_ff;
	logic [15:0] serial_ff;
	logic [15:0] date_ff;
	logic [15:0] hwopt_ff;
	logic [15:0] lang_ff;
	logic [15:0] arch_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_cnt_ff <= '0;
		end else if (strap_cnt_ff != 2'h3) begin
			strap_cnt_ff <= strap_cnt_ff + 2'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_ff <= '0;
			date_ff <= '0;
			hwopt_ff <= '0;
			lang_ff <= '0;
		end else if (strap_cnt_ff == tsr_pkg::STRAP_CAPTURE_CNT) begin
			// RULE11 serial number
			serial_ff <= strap_s[33:18];
			// RULE12 year and month
			date_ff <= '0;
			date_ff[tsr_pkg::DATE_YEAR_LSB +: 6] <= strap_s[17:12];
			date_ff[tsr_pkg::DATE_MONTH_LSB +: 6] <= strap_s[11:6];
			// RULE13 RULE14 power and accessory
			hwopt_ff <= '0;
			hwopt_ff[tsr_pkg::HW_POWER_LSB +: 2] <= strap_s[5:4];
			hwopt_ff[tsr_pkg::HW_ACCESSORY_LSB +: 3] <= strap_s[3:1];
			// RULE15 language bit
			lang_ff <= '0;
			lang_ff[tsr_pkg::LANG_BIT] <= strap_s[0];
		end
	end

	// RULE16 archive start clamp
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arch_ff <= '0;
		end else if (archive_start_page > tsr_pkg::ARCH_PAGE_MAX) begin
			arch_ff <= {2'h0, tsr_pkg::ARCH_PAGE_MAX};
		end else begin
			arch_ff <= {2'h0, archive_start_page};
		end
	end

	// =====================================================================
	// apb read decode
	logic [13:0] idx;
	logic [15:0] rd_word;
	logic rd_hit;

	assign idx = paddr[15:2];

	// RULE17 reserved and unmapped read zero
	always_comb begin
		rd_word = '0;
		rd_hit = 1'b1;
		if (paddr[1:0] != 2'h0) begin
			rd_hit = 1'b0;
		end else if (idx == tsr_pkg::IDX_CARD_STATE) begin
			rd_word = {13'h0000, card_code};
		end else if (idx == tsr_pkg::IDX_MEAS_FLAGS) begin
			rd_word = meas_ff;
		end else if (idx == tsr_pkg::IDX_NET_STATE) begin
			rd_word = net_ff;
		end else if (idx == tsr_pkg::IDX_RESERVED) begin
			rd_word = '0;
		end else if (idx == tsr_pkg::IDX_SERIAL) begin
			rd_word = serial_ff;
		end else if (idx == tsr_pkg::IDX_PROD_DATE) begin
			rd_word = date_ff;
		end else if (idx == tsr_pkg::IDX_HW_OPTIONS) begin
			rd_word = hwopt_ff;
		end else if (idx == tsr_pkg::IDX_LANGUAGE) begin
			rd_word = lang_ff;
		end else if (idx == tsr_pkg::IDX_ARCH_START) begin
			rd_word = arch_ff;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// answer in the first access cycle; writes are ignored
	logic setup_ph;
	assign setup_ph = psel && !penable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= tsr_pkg::RD_RESET;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph && !rd_hit;
			// RULE17 write has no effect
			if (setup_ph && !pwrite) begin
				prdata <= {16'h0000, rd_word};
			end else begin
				prdata <= tsr_pkg::RD_RESET;
			end
		end
	end

	// =====================================================================
	// assertions
	property p_code_legal;
		@(posedge pclk) disable iff (!presetn)
		card_code != 3'h7;
	endproperty
	a_code_legal: assert property (p_code_legal) else $error("card code 7 seen"); // RULE1

	property p_install_done;
		@(posedge pclk) disable iff (!presetn)
		(card_st_ff == tsr_pkg::TSR_ST_INSTALLING && det_s && !err_s && done_s)
			|=> (card_code == 3'h4) ##0 card_mounted;
	endproperty
	a_install_done: assert property (p_install_done) else $error("install did not give code 4"); // RULE1

	property p_wprot_unmount;
		@(posedge pclk) disable iff (!presetn)
		(card_st_ff == tsr_pkg::TSR_ST_INSTALLED && det_s && wp_s)
			|=> (card_code == 3'h3) && !card_mounted;
	endproperty
	a_wprot_unmount: assert property (p_wprot_unmount) else $error("write-protect not uninstalled"); // RULE2

	property p_meas_below;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn, 3) |-> (meas_ff[7] == $past(volt_below, 3)) && (meas_ff[8] == $past(curr_below, 3));
	endproperty
	a_meas_below: assert property (p_meas_below) else $error("below flags wrong"); // RULE3

	property p_meas_above;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn, 3) |-> (meas_ff[9] == $past(volt_above, 3)) && (meas_ff[10] == $past(curr_above, 3));
	endproperty
	a_meas_above: assert property (p_meas_above) else $error("above flags wrong"); // RULE4

	property p_net_bits;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn, 3) |-> (net_ff[0] == $past(net_fitted, 3)) && (net_ff[3] == $past(net_connected, 3))
			&& (net_ff[7] == $past(net_ftp_up, 3)) && (net_ff[9] == 1'b0);
	endproperty
	a_net_bits: assert property (p_net_bits) else $error("network flags wrong"); // RULE5

	property p_clk_lost;
		@(posedge pclk) disable iff (!presetn)
		(clk_idle_ff == TIMEOUT && !clk_edge) |=> !net_ff[10];
	endproperty
	a_clk_lost: assert property (p_clk_lost) else $error("clock loss not shown"); // RULE10

	property p_serial_read;
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && paddr == 16'h4350 && strap_cnt_ff == 2'h3)
			|=> pready && !pslverr && (prdata == {16'h0000, serial_ff});
	endproperty
	a_serial_read: assert property (p_serial_read) else $error("serial read wrong"); // RULE11

	property p_date_rsvd;
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && paddr == 16'h4354) |=> prdata[31:12] == 20'h00000;
	endproperty
	a_date_rsvd: assert property (p_date_rsvd) else $error("date reserved bits set"); // RULE12

	property p_arch_max;
		@(posedge pclk) disable iff (!presetn)
		arch_ff <= 16'h2000;
	endproperty
	a_arch_max: assert property (p_arch_max) else $error("archive page above limit"); // RULE16

	property p_write_quiet;
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && pwrite) |=> pready && (prdata == 32'h0000_0000);
	endproperty
	a_write_quiet: assert property (p_write_quiet) else $error("write returned data"); // RULE17

endmodule : tsr_status_bank

`default_nettype wire

// ===== tsr_pkg.sv
/*
 * tsr_pkg: shared constants for the transducer status register bank.
 * Assumes a 16-bit APB byte address; each register sits at four times its index.
 */
`default_nettype none

package tsr_pkg;

	// =====================================================================
	// register indices (byte address is four times the index)
	localparam logic [13:0] IDX_CARD_STATE = 14'h10d0;
	localparam logic [13:0] IDX_MEAS_FLAGS = 14'h10d1;
	localparam logic [13:0] IDX_NET_STATE = 14'h10d2;
	localparam logic [13:0] IDX_RESERVED = 14'h10d3;
	localparam logic [13:0] IDX_SERIAL = 14'h10d4;
	localparam logic [13:0] IDX_PROD_DATE = 14'h10d5;
	localparam logic [13:0] IDX_HW_OPTIONS = 14'h10d6;
	localparam logic [13:0] IDX_LANGUAGE = 14'h10d7;
	localparam logic [13:0] IDX_ARCH_START = 14'h10d8;

	// =====================================================================
	// card state codes
	localparam logic [2:0] CARD_ABSENT = 3'h0;
	localparam logic [2:0] CARD_UNINSTALLED = 3'h1;
	localparam logic [2:0] CARD_FAILED = 3'h2;
	localparam logic [2:0] CARD_WPROT = 3'h3;
	localparam logic [2:0] CARD_INSTALLED = 3'h4;
	localparam logic [2:0] CARD_FULL = 3'h5;
	localparam logic [2:0] CARD_INSTALLING = 3'h6;

	// =====================================================================
	// field positions
	localparam int MEAS_VOLT_BELOW = 7;
	localparam int MEAS_CURR_BELOW = 8;
	localparam int MEAS_VOLT_ABOVE = 9;
	localparam int MEAS_CURR_ABOVE = 10;
	localparam int NET_FITTED = 0;
	localparam int NET_ANEG_BUSY = 1;
	localparam int NET_ANEG_DONE = 2;
	localparam int NET_CONNECTED = 3;
	localparam int NET_DHCP_LEASE = 4;
	localparam int NET_DHCP_RENEW = 5;
	localparam int NET_CABLE_OK = 6;
	localparam int NET_FTP_UP = 7;
	localparam int NET_POWER_SAVE = 8;
	localparam int NET_CLK_OK = 10;
	localparam int DATE_YEAR_LSB = 6;
	localparam int DATE_MONTH_LSB = 0;
	localparam int HW_POWER_LSB = 14;
	localparam int HW_ACCESSORY_LSB = 5;
	localparam int LANG_BIT = 6;

	// =====================================================================
	// values, reset values and timing
	localparam logic [1:0] POWER_HIGH = 2'h1;
	localparam logic [1:0] POWER_LOW = 2'h2;
	localparam logic [2:0] ACC_NONE = 3'h0;
	localparam logic [2:0] ACC_SLOT = 3'h1;
	localparam logic [2:0] ACC_NET_MEM = 3'h2;
	localparam logic [13:0] ARCH_PAGE_MAX = 14'h2000;
	localparam logic [31:0] RD_RESET = 32'h0000_0000;
	localparam logic [1:0] STRAP_CAPTURE_CNT = 2'h2;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int NET_CLK_TIMEOUT_NS = 1000;
	localparam int NET_CLK_TIMEOUT_CYC = (NET_CLK_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;

	typedef enum logic [2:0] {
		TSR_ST_ABSENT,
		TSR_ST_UNINSTALLED,
		TSR_ST_FAILED,
		TSR_ST_WPROT,
		TSR_ST_INSTALLING,
		TSR_ST_INSTALLED,
		TSR_ST_FULL
	} tsr_card_st_t;

endpackage : tsr_pkg

`default_nettype wire

// ===== tsr_status_bank_test.sv
/*
 * tsr_status_bank_test: self-checking bench for the transducer status register bank.
 * Assumes tsr_pkg and tsr_status_bank are compiled first; the bench is the APB master
 * and drives every status pin and strap itself.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
	$display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end

module tsr_status_bank_test;
	// =====================================================================
	// signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic card_mounted;
	logic [5:0] cardv = 6'h00;
	logic [3:0] meas = 4'h0;
	logic [8:0] netv = 9'h000;
	logic nclk = 1'b0;
	logic nclk_en = 1'b0;
	logic [15:0] s_serial = 16'h0000;
	logic [5:0] s_year = 6'h00;
	logic [5:0] s_month = 6'h00;
	logic [1:0] s_power = 2'h1;
	logic [2:0] s_acc = 3'h0;
	logic s_lang = 1'b0;
	logic [13:0] arch = 14'h0000;
	int bad_count = 0;
	int cmp_count = 0;
	logic [8:0] card_tbl [12] = '{9'h009, 9'h01e, 9'h02c, 9'h10d, 9'h18b, 9'h00b,
		9'h01e, 9'h02c, 9'h08b, 9'h01e, 9'h06a, 9'h000};
	logic [13:0] arch_tbl [5] = '{14'h0000, 14'h2000, 14'h2001, 14'h3fff, 14'h1234};
	logic [15:0] bad_addr [4] = '{16'h433c, 16'h4364, 16'h4341, 16'h0000};

	always #2.5 pclk = ~pclk;

	// network clock runs only while enabled
	always @(posedge pclk) begin
		if (nclk_en) begin
			nclk <= ~nclk;
		end
	end

	// =====================================================================
	// design
	tsr_status_bank #(.CLK_TIMEOUT_CYC(20)) i_tsr_status_bank (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.card_detect(cardv[0]), .card_install_req(cardv[1]), .card_install_done(cardv[2]),
		.card_install_err(cardv[3]), .card_wprot(cardv[4]), .card_full_det(cardv[5]),
		.volt_below(meas[0]), .curr_below(meas[1]), .volt_above(meas[2]), .curr_above(meas[3]),
		.net_fitted(netv[0]), .net_aneg_busy(netv[1]), .net_aneg_done(netv[2]),
		.net_connected(netv[3]), .net_dhcp_lease(netv[4]), .net_dhcp_renew(netv[5]),
		.net_cable_ok(netv[6]), .net_ftp_up(netv[7]), .net_power_save(netv[8]),
		.net_ref_clk(nclk), .strap_serial(s_serial), .strap_year(s_year), .strap_month(s_month),
		.strap_power(s_power), .strap_accessory(s_acc), .strap_language(s_lang),
		.archive_start_page(arch), .card_mounted(card_mounted)
	);

	// =====================================================================
	// expectations
	function automatic logic [15:0] ba(input logic [13:0] idx);
		return {idx, 2'b00};
	endfunction : ba

	function automatic logic [31:0] arch_exp(input logic [13:0] v);
		return {18'h0, (v > 14'h2000) ? 14'h2000 : v};
	endfunction : arch_exp

	// =====================================================================
	// closing and bus tasks
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic apb(input logic wr, input logic [15:0] a, output logic [31:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= $urandom();
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED pready expected 1 seen %b", pready);
			tally_and_finish();
		end
	endtask : apb

	task automatic rd_exp(input logic [15:0] a, input logic [31:0] e, input string what);
		logic [31:0] d;
		logic er;
		apb(1'b0, a, d, er);
		`CHK(what, e, d)
		`CHK("slverr", 32'h0, {31'h0, er})
	endtask : rd_exp

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask : do_reset

	// =====================================================================
	// main sequence
	initial begin
		logic [31:0] d;
		logic er;
		logic [2:0] code;
		void'($urandom(49473));
		do_reset();
		// card state walk: pins then expected code
		foreach (card_tbl[i]) begin
			cardv <= card_tbl[i][8:3];
			code = card_tbl[i][2:0];
			repeat (5) @(posedge pclk);
			rd_exp(ba(tsr_pkg::IDX_CARD_STATE), {29'h0, code}, "card");
			`CHK("mounted", code == 3'h4 || code == 3'h5, card_mounted)
		end
		// threshold flags, all-set corner first
		for (int i = 0; i < 9; i++) begin
			meas <= (i == 0) ? 4'hf : 4'($urandom());
			repeat (4) @(posedge pclk);
			rd_exp(ba(tsr_pkg::IDX_MEAS_FLAGS), {21'h0, meas, 7'h0}, "meas");
		end
		// network flags with the interface clock running
		nclk_en <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			netv <= (i == 0) ? 9'h1ff : 9'($urandom());
			repeat (4) @(posedge pclk);
			rd_exp(ba(tsr_pkg::IDX_NET_STATE), {21'h0, 1'b1, 1'b0, netv}, "net");
		end
		nclk_en <= 1'b0;
		repeat (40) @(posedge pclk);
		rd_exp(ba(tsr_pkg::IDX_NET_STATE), {21'h0, 1'b0, 1'b0, netv}, "netclk");
		// production straps, captured after each reset
		for (int i = 0; i < 4; i++) begin
			s_serial <= (i == 0) ? 16'hffff : 16'($urandom());
			s_year <= (i == 0) ? 6'h3f : 6'($urandom());
			s_month <= 6'($urandom_range(12, 0));
			s_power <= (i % 2 == 0) ? tsr_pkg::POWER_HIGH : tsr_pkg::POWER_LOW;
			s_acc <= 3'(i % 3);
			s_lang <= i[0];
			do_reset();
			`CHK("mounted_rst", 1'b0, card_mounted)
			rd_exp(ba(tsr_pkg::IDX_SERIAL), {16'h0, s_serial}, "serial");
			rd_exp(ba(tsr_pkg::IDX_PROD_DATE), {20'h0, s_year, s_month}, "date");
			rd_exp(ba(tsr_pkg::IDX_HW_OPTIONS), {16'h0, s_power, 6'h0, s_acc, 5'h0}, "hwopt");
			rd_exp(ba(tsr_pkg::IDX_LANGUAGE), {25'h0, s_lang, 6'h0}, "lang");
			rd_exp(ba(tsr_pkg::IDX_RESERVED), 32'h0, "rsvd");
		end
		// archive page with clamp corners
		foreach (arch_tbl[i]) begin
			arch <= arch_tbl[i];
			repeat (2) @(posedge pclk);
			rd_exp(ba(tsr_pkg::IDX_ARCH_START), arch_exp(arch), "arch");
		end
		// writes to every mapped word are ignored without error
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, ba(tsr_pkg::IDX_CARD_STATE + 14'(i)), d, er);
			`CHK("wr_err", 32'h0, {31'h0, er})
			`CHK("wr_data", 32'h0, d)
		end
		rd_exp(ba(tsr_pkg::IDX_SERIAL), {16'h0, s_serial}, "serial_after_wr");
		rd_exp(ba(tsr_pkg::IDX_ARCH_START), arch_exp(arch), "arch_after_wr");
		// unmapped and unaligned places answer with an error
		foreach (bad_addr[i]) begin
			apb(i[0], bad_addr[i], d, er);
			`CHK("bad_err", 32'h1, {31'h0, er})
			`CHK("bad_data", 32'h0, d)
		end
		tally_and_finish();
	end
endmodule : tsr_status_bank_test

`default_nettype wire
